// ===== bench/dper_evbuf.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Main event buffer
// ----------------------------------------------------------------------
module dper_evbuf (
  input wire clk,
  input wire ev_valid,
  input wire [4:0] ev_code,
  input wire [47:0] ev_stamp
);
  logic [52:0] q[$];
  // Sampled on the falling edge so the stored pulse is settled.
  always @(negedge clk) begin
    if (ev_valid) q.push_back({ev_code, ev_stamp});
  end
endmodule // dper_evbuf

// ===== bench/dper_props.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module dper_props #(
  parameter DEPTH = 12
) (
  input wire clk,
  input wire rst,
  input wire bias_trip_in,
  input wire bias_ext_block,
  input wire nobias_trip_in,
  input wire hv_trip_in,
  input wire hv_ext_block,
  input wire lv_trip_in,
  input wire lv_ext_block,
  input wire bias_trip,
  input wire bias_blocked,
  input wire nobias_trip,
  input wire hv_trip,
  input wire lv_trip,
  input wire ev_valid,
  input wire [4:0] ev_code,
  input wire [47:0] ev_stamp,
  input wire [47:0] time_ms,
  input wire [15:0] store_on_en,
  input wire [15:0] store_off_en,
  input wire [3:0] counter_clear,
  input wire [15:0] cnt_trip,
  input wire [3:0] rec_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // The $past(rst) guards keep the first edge after a reset quiet.
  a_bias_gate: assert property (
    !$past(rst) |-> bias_trip == $past(bias_trip_in & ~bias_ext_block))
    else $error("biased trip not gated by its block");
  a_nobias_raw: assert property (
    !$past(rst) |-> nobias_trip == $past(nobias_trip_in))
    else $error("unbiased trip does not follow its input");
  a_blocked_follow: assert property (
    !$past(rst) |-> bias_blocked == $past(bias_ext_block))
    else $error("blocked output does not follow block input");
  a_ref_sides: assert property (
    !$past(rst) |-> hv_trip == $past(hv_trip_in & ~hv_ext_block) &&
    lv_trip == $past(lv_trip_in & ~lv_ext_block))
    else $error("earth fault trips not independent");
  a_event_first: assert property (
    $rose(bias_trip) && store_on_en[0] |=>
    ev_valid && ev_code == 5'h00)
    else $error("trip ON event missing");
  a_stamp_drain: assert property (
    ev_valid |-> ev_stamp == $past(time_ms))
    else $error("event stamp is not drain time");
  a_store_mask: assert property (
    ev_valid |-> (((ev_code[0] ? $past(store_off_en) : $past(store_on_en))
    >> ev_code[4:1]) & 16'h0001) != 16'h0000)
    else $error("masked event was stored");
  a_rec_step: assert property (
    !$past(rst) && $changed(rec_count) |->
    rec_count == $past(rec_count) + 4'h1)
    else $error("record count moved wrongly");
  a_rec_full: assert property (
    rec_count == DEPTH |=> rec_count == DEPTH)
    else $error("full record store changed count");
  a_cnt_step: assert property (
    !$past(rst) && !$past(counter_clear[0]) && $changed(cnt_trip) |->
    cnt_trip == $past(cnt_trip) + 16'h0001)
    else $error("trip counter step wrong");
  a_cnt_clear: assert property (
    !$past(rst) && $past(counter_clear[0]) |-> cnt_trip <= 16'h0001)
    else $error("trip counter not cleared");

  c_event: cover property (ev_valid);
  c_full: cover property (rec_count == DEPTH);
  c_cnt: cover property (cnt_trip == 16'h0002);
endmodule // dper_props

bind dper_top dper_props #(.DEPTH(DEPTH)) u_props (.*);

// ===== bench/dper_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
// ----------------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------------
module dper_top_tb;
  logic clk = 1'b0, rst = 1'b1;
  logic signed [15:0] ph1_cur_a = 16'sd100, ph1_cur_b = 16'sd100;
  logic signed [15:0] ph2_cur_a = 16'sd100, ph2_cur_b = -16'sd100;
  logic signed [15:0] ph3_cur_a = 16'sd100, ph3_cur_b = -16'sd100;
  logic signed [15:0] hv_cur_a = 16'sd40, hv_cur_b = 16'sd20;
  logic signed [15:0] lv_cur_a = 16'sd0, lv_cur_b = 16'sd0;
  logic [15:0] ph_pickup = 16'h0032, ph_turn1 = 16'h03e8;
  logic [15:0] ph_turn2 = 16'h07d0, hv_pickup = 16'h0032;
  logic [15:0] hv_turn1 = 16'h03e8, hv_turn2 = 16'h07d0;
  logic [15:0] lv_pickup = 16'h0032, lv_turn1 = 16'h03e8;
  logic [15:0] lv_turn2 = 16'h07d0;
  logic [9:0] ph_slope1 = 10'h080, ph_slope2 = 10'h100;
  logic [9:0] hv_slope1 = 10'h080, hv_slope2 = 10'h100;
  logic [9:0] lv_slope1 = 10'h080, lv_slope2 = 10'h100;
  logic bias_trip_in = 1'b0, bias_ext_block = 1'b0, nobias_trip_in = 1'b0;
  logic nobias_ext_block = 1'b0, h2_block_in = 1'b0, h5_block_in = 1'b0;
  logic hv_trip_in = 1'b0, hv_ext_block = 1'b0, lv_trip_in = 1'b0;
  logic lv_ext_block = 1'b0;
  logic [2:0] phase_h2_in = 3'h0, phase_h5_in = 3'h0, setting_group = 3'h0;
  logic [15:0] store_on_en = 16'hffff, store_off_en = 16'hffff;
  logic [47:0] time_ms = 48'h0;
  logic [3:0] counter_clear = 4'h0, rec_sel = 4'h0;
  wire [15:0] phase1_bias_current, phase1_diff_current;
  wire [15:0] phase1_allowed_diff_current, phase2_bias_current;
  wire [15:0] phase2_diff_current, phase2_allowed_diff_current;
  wire [15:0] phase3_bias_current, phase3_diff_current;
  wire [15:0] phase3_allowed_diff_current, hv_bias_current;
  wire [15:0] hv_diff_current, hv_allowed_diff_current, lv_bias_current;
  wire [15:0] lv_diff_current, lv_allowed_diff_current;
  wire bias_trip, bias_blocked, nobias_trip, nobias_blocked, h2_block_on;
  wire h5_block_on, hv_trip, hv_blocked, lv_trip, lv_blocked, ev_valid;
  wire rec_valid;
  wire [4:0] ev_code, rec_event;
  wire [47:0] ev_stamp, rec_stamp;
  wire [15:0] cnt_trip, cnt_h2, cnt_h5, cnt_ext;
  wire [3:0] rec_count;
  wire [2:0] rec_group, rec_ftype;
  wire [239:0] rec_currents;
  int errors = 0, cmp_count = 0;

  dper_top dut (.*);
  dper_evbuf eb (.*);

  always #4 clk = ~clk;
  always @(negedge clk) time_ms <= time_ms + 48'h1;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic t_outputs();
    bias_trip_in = 1'b1;
    bias_ext_block = 1'b1;
    nobias_trip_in = 1'b1;
    nobias_ext_block = 1'b1;
    hv_trip_in = 1'b1;
    lv_trip_in = 1'b1;
    lv_ext_block = 1'b1;
    cyc(2);
    `CHK(bias_trip, 1'b0)
    `CHK(bias_blocked, 1'b1)
    `CHK(nobias_trip, 1'b1)
    `CHK(nobias_blocked, 1'b1)
    `CHK({hv_trip, lv_trip, lv_blocked}, 3'h5)
    bias_ext_block = 1'b0;
    cyc(2);
    `CHK(bias_trip, 1'b1)
    {bias_trip_in, nobias_trip_in, nobias_ext_block} = 3'h0;
    {hv_trip_in, lv_trip_in, lv_ext_block} = 3'h0;
    cyc(40);
    `CHK(phase1_bias_current, 16'd100)
    `CHK(phase1_diff_current, 16'd200)
    `CHK(phase1_allowed_diff_current, 16'd50)
    `CHK(phase2_diff_current, 16'd0)
    `CHK({hv_bias_current, hv_diff_current}, {16'd30, 16'd60})
    `CHK(lv_allowed_diff_current, 16'd50)
    `CHK(phase2_bias_current, 16'h0064)
    `CHK(phase2_allowed_diff_current, 16'h0032)
    `CHK(hv_allowed_diff_current, 16'h0032)
    // Phase 3 lands on the first slope, the low side beyond the knee.
    ph3_cur_a = 16'sh05dc;
    ph3_cur_b = -16'sh0514;
    lv_cur_a = 16'sh0bb8;
    lv_cur_b = 16'sh07d0;
    cyc(4);
    `CHK(phase3_bias_current, 16'h0578)
    `CHK(phase3_diff_current, 16'h00c8)
    `CHK(phase3_allowed_diff_current, 16'h00fa)
    `CHK({lv_bias_current, lv_diff_current}, 32'h09c41388)
    `CHK(lv_allowed_diff_current, 16'h041a)
  endtask

  task automatic t_events();
    logic [47:0] t;
    eb.q.delete();
    store_on_en = 16'hfffd;
    bias_ext_block = 1'b1;
    cyc(4);
    bias_ext_block = 1'b0;
    t = time_ms;
    cyc(4);
    `CHK(eb.q.size(), 1)
    `CHK(eb.q[0], {5'h03, t + 48'h2})
    eb.q.delete();
    store_on_en = 16'hffff;
    store_off_en = 16'hffdf;
    h5_block_in = 1'b1;
    t = time_ms;
    cyc(4);
    h5_block_in = 1'b0;
    cyc(4);
    `CHK(eb.q.size(), 1)
    `CHK(eb.q[0], {5'h0a, t + 48'h2})
    store_off_en = 16'hffff;
  endtask

  task automatic t_counters();
    counter_clear = 4'hf;
    cyc(1);
    `CHK({cnt_trip, cnt_h2, cnt_h5, cnt_ext}, 64'h0)
    counter_clear = 4'h0;
    {bias_trip_in, h2_block_in, h5_block_in, hv_ext_block} = 4'hf;
    cyc(2);
    `CHK({h2_block_on, h5_block_on, hv_blocked}, 3'h7)
    {bias_trip_in, h2_block_in, h5_block_in, hv_ext_block} = 4'h0;
    nobias_trip_in = 1'b1;
    lv_trip_in = 1'b1;
    cyc(2);
    {nobias_trip_in, lv_trip_in} = 2'h0;
    cyc(40);
    `CHK(cnt_trip, 16'h0002)
    `CHK({cnt_h2, cnt_h5, cnt_ext}, {16'h1, 16'h1, 16'h1})
    counter_clear = 4'h1;
    bias_trip_in = 1'b1;
    cyc(1);
    counter_clear = 4'h0;
    cyc(1);
    `CHK({cnt_trip, cnt_h2}, {16'h1, 16'h1})
    bias_trip_in = 1'b0;
    cyc(20);
  endtask

  task automatic t_records();
    logic [47:0] st[13];
    for (int i = 0; i < 13; i++) begin
      setting_group = i[2:0];
      bias_trip_in = 1'b1;
      st[i] = time_ms + 48'h2;
      cyc(3);
      bias_trip_in = 1'b0;
      cyc(3);
    end
    `CHK(rec_count, 4'hc)
    rec_sel = 4'h0;
    cyc(2);
    `CHK({rec_valid, rec_event}, 6'h20)
    `CHK(rec_stamp, st[12])
    `CHK({rec_group, rec_ftype}, 6'h21)
    `CHK(rec_currents[47:0], {16'd50, 16'd200, 16'd100})
    `CHK(rec_currents[191:144], {16'd50, 16'd60, 16'd30})
    rec_sel = 4'hb;
    cyc(2);
    `CHK({rec_stamp, rec_group}, {st[1], 3'h1})
    rec_sel = 4'hc;
    cyc(2);
    `CHK(rec_valid, 1'b0)
  endtask

  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(2);
    t_outputs();
    t_events();
    t_counters();
    t_records();
    finish_test();
  end

  // The tests need well under 500 cycles; this leaves ample margin.
  initial begin
    #40000;
    errors++;
    finish_test();
  end
endmodule // dper_top_tb

// ===== core/dper_char.v
`timescale 1ns/10ps
`include "dper_map.vh"

module dper_char #(
  parameter W = `DPER_CUR_W,
  parameter SW = `DPER_SLOPE_W,
  parameter FR = `DPER_SLOPE_FRAC
) (
  input wire clk,
  input wire rst,
  input wire signed [W-1:0] cur_a,
  input wire signed [W-1:0] cur_b,
  input wire [W-1:0] pickup,
  input wire [W-1:0] turn1,
  input wire [SW-1:0] slope1,
  input wire [W-1:0] turn2,
  input wire [SW-1:0] slope2,
  output reg [W-1:0] bias,
  output reg [W-1:0] diff,
  output reg [W-1:0] allowed
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function [W-1:0] mag;
    input [W-1:0] v;
    begin
      mag = v[W-1] ? (~v + 1'b1) : v;
    end
  endfunction

  // Slopes are fixed point with FR fraction bits; results saturate.
  function [W-1:0] ramp;
    input [W-1:0] base;
    input [W-1:0] dlt;
    input [SW-1:0] sl;
    reg [W+SW-1:0] p;
    reg [W:0] s;
    begin
      p = dlt * sl;
      s = {1'b0, base} + {1'b0, p[W+FR-1:FR]};
      ramp = (s[W] | (|p[W+SW-1:W+FR])) ? {W{1'b1}} : s[W-1:0];
    end
  endfunction

  reg [W-1:0] bias_s1;
  reg [W-1:0] diff_s1;
  reg [W:0] next_sum;
  reg [W:0] next_sd;
  reg [W:0] next_dm;
  reg [W-1:0] knee;
  reg [W-1:0] next_allowed;

  // --------------------------------------------------------------------
  // Bias, differential and permitted differential
  // --------------------------------------------------------------------
  always @* begin
    next_sum = {1'b0, mag(cur_a)} + {1'b0, mag(cur_b)};
    next_sd = {cur_a[W-1], cur_a} + {cur_b[W-1], cur_b};
    next_dm = next_sd[W] ? (~next_sd + 1'b1) : next_sd;
    knee = (turn2 > turn1) ? ramp(pickup, turn2 - turn1, slope1) : pickup;
    if (bias_s1 <= turn1) begin
      next_allowed = pickup;
    end else if (bias_s1 <= turn2) begin
      next_allowed = ramp(pickup, bias_s1 - turn1, slope1);
    end else begin
      next_allowed = ramp(knee, bias_s1 - turn2, slope2);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      bias_s1 <= {W{1'b0}};
      diff_s1 <= {W{1'b0}};
      bias <= {W{1'b0}};
      diff <= {W{1'b0}};
      allowed <= {W{1'b0}};
    end else begin
      bias_s1 <= next_sum[W:1];
      diff_s1 <= next_dm[W] ? {W{1'b1}} : next_dm[W-1:0];
      bias <= bias_s1;
      diff <= diff_s1;
      allowed <= next_allowed;
    end
  end

endmodule // dper_char

// ===== core/dper_top.v
`timescale 1ns/10ps
`include "dper_map.vh"


module dper_top #(
  parameter W = `DPER_CUR_W,
  parameter SW = `DPER_SLOPE_W,
  parameter TSW = `DPER_TS_W,
  parameter CW = `DPER_CNT_W,
  parameter DEPTH = `DPER_REC_DEPTH
) (
  input wire clk,
  input wire rst,
  input wire signed [W-1:0] ph1_cur_a,
  input wire signed [W-1:0] ph1_cur_b,
  input wire signed [W-1:0] ph2_cur_a,
  input wire signed [W-1:0] ph2_cur_b,
  input wire signed [W-1:0] ph3_cur_a,
  input wire signed [W-1:0] ph3_cur_b,
  input wire signed [W-1:0] hv_cur_a,
  input wire signed [W-1:0] hv_cur_b,
  input wire signed [W-1:0] lv_cur_a,
  input wire signed [W-1:0] lv_cur_b,
  input wire [W-1:0] ph_pickup,
  input wire [W-1:0] ph_turn1,
  input wire [SW-1:0] ph_slope1,
  input wire [W-1:0] ph_turn2,
  input wire [SW-1:0] ph_slope2,
  input wire [W-1:0] hv_pickup,
  input wire [W-1:0] hv_turn1,
  input wire [SW-1:0] hv_slope1,
  input wire [W-1:0] hv_turn2,
  input wire [SW-1:0] hv_slope2,
  input wire [W-1:0] lv_pickup,
  input wire [W-1:0] lv_turn1,
  input wire [SW-1:0] lv_slope1,
  input wire [W-1:0] lv_turn2,
  input wire [SW-1:0] lv_slope2,
  input wire bias_trip_in,
  input wire bias_ext_block,
  input wire nobias_trip_in,
  input wire nobias_ext_block,
  input wire h2_block_in,
  input wire h5_block_in,
  input wire [2:0] phase_h2_in,
  input wire [2:0] phase_h5_in,
  input wire hv_trip_in,
  input wire hv_ext_block,
  input wire lv_trip_in,
  input wire lv_ext_block,
  input wire [15:0] store_on_en,
  input wire [15:0] store_off_en,
  input wire [TSW-1:0] time_ms,
  input wire [2:0] setting_group,
  input wire [3:0] counter_clear,
  input wire [3:0] rec_sel,
  output wire [W-1:0] phase1_bias_current,
  output wire [W-1:0] phase1_diff_current,
  output wire [W-1:0] phase1_allowed_diff_current,
  output wire [W-1:0] phase2_bias_current,
  output wire [W-1:0] phase2_diff_current,
  output wire [W-1:0] phase2_allowed_diff_current,
  output wire [W-1:0] phase3_bias_current,
  output wire [W-1:0] phase3_diff_current,
  output wire [W-1:0] phase3_allowed_diff_current,
  output wire [W-1:0] hv_bias_current,
  output wire [W-1:0] hv_diff_current,
  output wire [W-1:0] hv_allowed_diff_current,
  output wire [W-1:0] lv_bias_current,
  output wire [W-1:0] lv_diff_current,
  output wire [W-1:0] lv_allowed_diff_current,
  output wire bias_trip,
  output wire bias_blocked,
  output wire nobias_trip,
  output wire nobias_blocked,
  output wire h2_block_on,
  output wire h5_block_on,
  output wire hv_trip,
  output wire hv_blocked,
  output wire lv_trip,
  output wire lv_blocked,
  output reg ev_valid,
  output reg [4:0] ev_code,
  output reg [TSW-1:0] ev_stamp,
  output reg [CW-1:0] cnt_trip,
  output reg [CW-1:0] cnt_h2,
  output reg [CW-1:0] cnt_h5,
  output reg [CW-1:0] cnt_ext,
  output reg [3:0] rec_count,
  output reg rec_valid,
  output reg [4:0] rec_event,
  output reg [TSW-1:0] rec_stamp,
  output reg [2:0] rec_group,
  output reg [2:0] rec_ftype,
  output reg [15*W-1:0] rec_currents
);

  localparam CURW = 15 * W;
  localparam RW = 5 + TSW + 3 + 3 + CURW;
  localparam [4:0] DEP5 = DEPTH[4:0];
  localparam [3:0] LAST = DEPTH[3:0] - 4'h1;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function [4:0] first_set;
    input [31:0] v;
    integer i;
    begin
      first_set = 5'h00;
      for (i = 31; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[4:0];
        end
      end
    end
  endfunction

  // An increment in the cycle of a clear leaves one count, not zero.
  function [CW-1:0] cnt_next;
    input [CW-1:0] c;
    input inc;
    input clr;
    begin
      if (inc) begin
        cnt_next = clr ? {{(CW-1){1'b0}}, 1'b1} :
                   ((&c) ? c : c + 1'b1);
      end else if (clr) begin
        cnt_next = {CW{1'b0}};
      end else begin
        cnt_next = c;
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Current characteristics
  // --------------------------------------------------------------------
  dper_char #(.W(W), .SW(SW)) u_ph1 (
    .clk(clk), .rst(rst), .cur_a(ph1_cur_a), .cur_b(ph1_cur_b),
    .pickup(ph_pickup), .turn1(ph_turn1), .slope1(ph_slope1),
    .turn2(ph_turn2), .slope2(ph_slope2), .bias(phase1_bias_current),
    .diff(phase1_diff_current), .allowed(phase1_allowed_diff_current));

  dper_char #(.W(W), .SW(SW)) u_ph2 (
    .clk(clk), .rst(rst), .cur_a(ph2_cur_a), .cur_b(ph2_cur_b),
    .pickup(ph_pickup), .turn1(ph_turn1), .slope1(ph_slope1),
    .turn2(ph_turn2), .slope2(ph_slope2), .bias(phase2_bias_current),
    .diff(phase2_diff_current), .allowed(phase2_allowed_diff_current));

  dper_char #(.W(W), .SW(SW)) u_ph3 (
    .clk(clk), .rst(rst), .cur_a(ph3_cur_a), .cur_b(ph3_cur_b),
    .pickup(ph_pickup), .turn1(ph_turn1), .slope1(ph_slope1),
    .turn2(ph_turn2), .slope2(ph_slope2), .bias(phase3_bias_current),
    .diff(phase3_diff_current), .allowed(phase3_allowed_diff_current));

  dper_char #(.W(W), .SW(SW)) u_hv (
    .clk(clk), .rst(rst), .cur_a(hv_cur_a), .cur_b(hv_cur_b),
    .pickup(hv_pickup), .turn1(hv_turn1), .slope1(hv_slope1),
    .turn2(hv_turn2), .slope2(hv_slope2), .bias(hv_bias_current),
    .diff(hv_diff_current), .allowed(hv_allowed_diff_current));

  dper_char #(.W(W), .SW(SW)) u_lv (
    .clk(clk), .rst(rst), .cur_a(lv_cur_a), .cur_b(lv_cur_b),
    .pickup(lv_pickup), .turn1(lv_turn1), .slope1(lv_slope1),
    .turn2(lv_turn2), .slope2(lv_slope2), .bias(lv_bias_current),
    .diff(lv_diff_current), .allowed(lv_allowed_diff_current));

  // --------------------------------------------------------------------
  // Stage status
  // --------------------------------------------------------------------
  // The unbiased stage is deliberately left ungated by its blocking
  // input; only its blocked indication follows that input.
  wire [15:0] stat_in = {
    lv_trip_in & ~lv_ext_block, lv_ext_block,
    hv_trip_in & ~hv_ext_block, hv_ext_block,
    phase_h5_in, phase_h2_in, h5_block_in, h2_block_in,
    nobias_ext_block, nobias_trip_in,
    bias_ext_block, bias_trip_in & ~bias_ext_block
  };
  reg [15:0] stat;

  assign bias_trip = stat[`DPER_S_BIAS_TRIP];
  assign bias_blocked = stat[`DPER_S_BIAS_BLK];
  assign nobias_trip = stat[`DPER_S_NOBIAS_TRIP];
  assign nobias_blocked = stat[`DPER_S_NOBIAS_BLK];
  assign h2_block_on = stat[`DPER_S_H2_BLK];
  assign h5_block_on = stat[`DPER_S_H5_BLK];
  assign hv_trip = stat[`DPER_S_HV_TRIP];
  assign hv_blocked = stat[`DPER_S_HV_BLK];
  assign lv_trip = stat[`DPER_S_LV_TRIP];
  assign lv_blocked = stat[`DPER_S_LV_BLK];

  wire [15:0] rise = stat_in & ~stat;
  wire [15:0] fall = ~stat_in & stat;

  // --------------------------------------------------------------------
  // Event queue
  // --------------------------------------------------------------------
  reg [31:0] pending;
  reg [31:0] ev_set;
  reg [31:0] next_pending;
  integer k;

  wire [4:0] pick = first_set(pending);
  wire any_pend = |pending;
  wire [31:0] ev_clr = any_pend ? (32'h00000001 << pick) : 32'h00000000;
  wire pick_store = pick[0] ? store_off_en[pick[4:1]] :
                    store_on_en[pick[4:1]];
  wire [15:0] trip_mask = `DPER_TRIP_MASK;
  wire pick_trip_on = any_pend & ~pick[0] & trip_mask[pick[4:1]];

  // A new change on a bit being drained in this cycle is kept pending.
  always @* begin
    ev_set = 32'h00000000;
    for (k = 0; k < 16; k = k + 1) begin
      ev_set[2*k] = rise[k];
      ev_set[2*k+1] = fall[k];
    end
    next_pending = (pending & ~ev_clr) | ev_set;
  end

  // --------------------------------------------------------------------
  // Record store
  // --------------------------------------------------------------------
  reg [RW-1:0] rec_mem [0:DEPTH-1];
  reg [3:0] wr_ptr;
  reg [4:0] rd_tmp;
  reg [3:0] rd_idx;
  integer m;

  wire [2:0] ftype = {phase3_diff_current > phase3_allowed_diff_current,
                      phase2_diff_current > phase2_allowed_diff_current,
                      phase1_diff_current > phase1_allowed_diff_current};
  wire [CURW-1:0] cur_all = {
    lv_allowed_diff_current, lv_diff_current, lv_bias_current,
    hv_allowed_diff_current, hv_diff_current, hv_bias_current,
    phase3_allowed_diff_current, phase3_diff_current, phase3_bias_current,
    phase2_allowed_diff_current, phase2_diff_current, phase2_bias_current,
    phase1_allowed_diff_current, phase1_diff_current, phase1_bias_current
  };

  // Selection 0 is the newest record.
  always @* begin
    rd_tmp = {1'b0, wr_ptr} + DEP5 - 5'h01 - {1'b0, rec_sel};
    if (rd_tmp >= DEP5) begin
      rd_tmp = rd_tmp - DEP5;
    end
    rd_idx = rd_tmp[3:0];
  end

  // --------------------------------------------------------------------
  // Sequential state
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      stat <= 16'h0000;
      pending <= 32'h00000000;
      ev_valid <= 1'b0;
      ev_code <= 5'h00;
      ev_stamp <= {TSW{1'b0}};
      cnt_trip <= {CW{1'b0}};
      cnt_h2 <= {CW{1'b0}};
      cnt_h5 <= {CW{1'b0}};
      cnt_ext <= {CW{1'b0}};
      wr_ptr <= 4'h0;
      rec_count <= 4'h0;
      rec_valid <= 1'b0;
      rec_event <= 5'h00;
      rec_stamp <= {TSW{1'b0}};
      rec_group <= 3'h0;
      rec_ftype <= 3'h0;
      rec_currents <= {CURW{1'b0}};
      for (m = 0; m < DEPTH; m = m + 1) begin
        rec_mem[m] <= {RW{1'b0}};
      end
    end else begin
      stat <= stat_in;
      pending <= next_pending;
      ev_valid <= any_pend & pick_store;
      if (any_pend) begin
        ev_code <= pick;
        ev_stamp <= time_ms;
      end
      cnt_trip <= cnt_next(cnt_trip, |(rise & `DPER_TRIP_MASK),
                           counter_clear[`DPER_C_TRIP]);
      cnt_h2 <= cnt_next(cnt_h2, |(rise & `DPER_H2_MASK),
                         counter_clear[`DPER_C_H2]);
      cnt_h5 <= cnt_next(cnt_h5, |(rise & `DPER_H5_MASK),
                         counter_clear[`DPER_C_H5]);
      cnt_ext <= cnt_next(cnt_ext, |(rise & `DPER_EXT_MASK),
                          counter_clear[`DPER_C_EXT]);
      if (pick_trip_on) begin
        rec_mem[wr_ptr] <= {pick, time_ms, setting_group, ftype,
                            cur_all};
        wr_ptr <= (wr_ptr == LAST) ? 4'h0 : wr_ptr + 4'h1;
        if (rec_count != DEPTH[3:0]) begin
          rec_count <= rec_count + 4'h1;
        end
      end
      rec_valid <= rec_sel < rec_count;
      {rec_event, rec_stamp, rec_group, rec_ftype, rec_currents} <=
        rec_mem[rd_idx];
    end
  end

endmodule // dper_top

// ===== include/dper_map.vh
`ifndef DPER_MAP_VH
`define DPER_MAP_VH

// ----------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------
`define DPER_CUR_W 16
`define DPER_SLOPE_W 10
`define DPER_SLOPE_FRAC 8
`define DPER_TS_W 48
`define DPER_CNT_W 16
`define DPER_REC_DEPTH 12
`define DPER_NSTAT 16
`define DPER_NEV 32

// ----------------------------------------------------------------------
// Status bit positions; event code is two times this, plus one for OFF
// ----------------------------------------------------------------------
`define DPER_S_BIAS_TRIP 4'h0
`define DPER_S_BIAS_BLK 4'h1
`define DPER_S_NOBIAS_TRIP 4'h2
`define DPER_S_NOBIAS_BLK 4'h3
`define DPER_S_H2_BLK 4'h4
`define DPER_S_H5_BLK 4'h5
`define DPER_S_PH_H2 4'h6
`define DPER_S_PH_H5 4'h9
`define DPER_S_HV_BLK 4'hc
`define DPER_S_HV_TRIP 4'hd
`define DPER_S_LV_BLK 4'he
`define DPER_S_LV_TRIP 4'hf

// ----------------------------------------------------------------------
// Status groups that feed the cumulative counters
// ----------------------------------------------------------------------
`define DPER_TRIP_MASK 16'ha005
`define DPER_EXT_MASK 16'h500a
`define DPER_H2_MASK 16'h0010
`define DPER_H5_MASK 16'h0020

// ----------------------------------------------------------------------
// Counter positions in the clear vector
// ----------------------------------------------------------------------
`define DPER_C_TRIP 2'h0
`define DPER_C_H2 2'h1
`define DPER_C_H5 2'h2
`define DPER_C_EXT 2'h3

`endif
